// ==== shared/dar_pkg.sv ====
// shared constants and types for the row-activation and read-burst block
package dar_pkg;
	// clock period in picoseconds (250 MHz)
	localparam int CLK_PS = 4000;
	// analog minimum times, in picoseconds
	localparam int T_RCD_PS = 15000;
	localparam int T_RAS_PS = 37500;
	localparam int T_RTP_PS = 7500;
	localparam int T_RP_PS = 15000;
	// minimum times rounded up to whole clocks, never below one
	localparam int RCD_CYC = ((T_RCD_PS + CLK_PS - 1) / CLK_PS < 1) ? 1 : (T_RCD_PS + CLK_PS - 1) / CLK_PS;
	localparam int RAS_CYC = ((T_RAS_PS + CLK_PS - 1) / CLK_PS < 1) ? 1 : (T_RAS_PS + CLK_PS - 1) / CLK_PS;
	localparam int RTP_CYC = ((T_RTP_PS + CLK_PS - 1) / CLK_PS < 1) ? 1 : (T_RTP_PS + CLK_PS - 1) / CLK_PS;
	localparam int RP_CYC = ((T_RP_PS + CLK_PS - 1) / CLK_PS < 1) ? 1 : (T_RP_PS + CLK_PS - 1) / CLK_PS;
	// floor of four clocks from the last prefetch to internal precharge
	localparam int PREF_TO_PRE_CLK = 4;
	localparam int RTP_EFF = (RTP_CYC > PREF_TO_PRE_CLK) ? RTP_CYC : PREF_TO_PRE_CLK;
	// geometry
	localparam int BANKS = 8;
	localparam int BA_W = 3;
	localparam int A_W = 14;
	localparam int COL_W = 10;
	localparam int AP_BIT = 10;
	localparam int BC_BIT = 12;
	localparam int WORD_AW = BA_W + COL_W - 1;
	// clock cycles of data per burst after the first (two beats per clock)
	localparam logic [1:0] CYC_BL8 = 2'h3;
	localparam logic [1:0] CYC_BC4 = 2'h1;
	// register byte offsets
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_MADDR = 8'h04;
	localparam logic [7:0] REG_MDATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_VIOL = 8'h10;
	// configuration fields
	localparam int CFG_CL_LSB = 0;
	localparam int CFG_AL_LSB = 4;
	localparam int CFG_BL_LSB = 8;
	localparam logic [3:0] CL_RST = 4'h5;
	localparam logic [3:0] AL_RST = 4'h0;
	localparam logic [1:0] BL_FIX8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIX4 = 2'h2;
	// status fields
	localparam int STAT_OPEN_LSB = 0;
	localparam int STAT_BUSY_BIT = 8;
	localparam int STAT_AP_LSB = 16;
	// violation flags
	localparam int V_CLOSED = 0;
	localparam int V_RCD = 1;
	localparam int V_RP = 2;
	localparam int V_TRUNC = 3;
	localparam int VIOL_W = 4;
	// command pins sampled on the rising clock edge
	typedef struct packed {
		logic cs_b;
		logic ras_b;
		logic cas_b;
		logic we_b;
		logic [BA_W-1:0] ba;
		logic [A_W-1:0] addr;
	} dar_cmd_t;
	// one queued read waiting out its latency
	typedef struct packed {
		logic vld;
		logic [BA_W-1:0] ba;
		logic [COL_W-1:0] col;
		logic bc4;
	} dar_rd_t;
	// burst engine states
	typedef enum logic [0:0] {
		BST_IDLE = 1'b0,
		BST_RUN = 1'b1
	} dar_bst_t;
endpackage : dar_pkg

// ==== hw/dar_mem.sv ====
// small data array with registered read port
`timescale 1ns/100ps
module dar_mem #(
	parameter int AW = 12,
	parameter int DW = 16
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata_r
);
	// storage, contents undefined after power-up
	logic [DW-1:0] mem [2**AW];

	// write port
	always_ff @(posedge clk_sys)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	// read port, data held until the next read
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			rdata_r <= '0;
		else if (re)
			rdata_r <= mem[raddr];
	end
endmodule : dar_mem

// ==== hw/dar_core.sv ====
// device-side row activation, read burst and auto precharge logic
`timescale 1ns/100ps
module dar_core #(
	parameter int DQ_W = 8,
	parameter int RL_MAX = 24
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dar_pkg::dar_cmd_t cmd,
	output logic [2*DQ_W-1:0] dq_o,
	output logic dq_oe,
	output logic dqs_o,
	output logic dqs_b_o,
	output logic dqs_oe
);
	// refuse shapes the logic cannot serve
	if (2 * DQ_W > 32 || DQ_W < 1)
		$error("dar_core: data word must fit one bus word");
	if (RL_MAX < 16 || RL_MAX > 31)
		$error("dar_core: RL_MAX out of range");

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// decode of the command pins into act, read, write, precharge
	function automatic logic [3:0] dar_decode(input dar_pkg::dar_cmd_t c);
		logic [3:0] d;
		d = 4'h0;
		if (!c.cs_b)
		begin
			d[3] = !c.ras_b && c.cas_b && c.we_b;
			d[2] = c.ras_b && !c.cas_b && c.we_b;
			d[1] = c.ras_b && !c.cas_b && !c.we_b;
			d[0] = !c.ras_b && c.cas_b && !c.we_b;
		end
		return d;
	endfunction : dar_decode

	// word address of the k-th clock of a burst, wrapping inside the burst
	function automatic logic [dar_pkg::WORD_AW-1:0] dar_waddr(input logic [dar_pkg::BA_W-1:0] ba,
		input logic [dar_pkg::COL_W-1:0] col, input logic [1:0] k, input logic bc4);
		logic [1:0] w;
		w = col[2:1] + k;
		if (bc4)
			w[1] = col[2];
		return {ba, col[dar_pkg::COL_W-1:3], w};
	endfunction : dar_waddr

	// mapped register offsets
	function automatic logic dar_mapped(input logic [7:0] a);
		return a == dar_pkg::REG_CFG || a == dar_pkg::REG_MADDR || a == dar_pkg::REG_MDATA ||
			a == dar_pkg::REG_STAT || a == dar_pkg::REG_VIOL;
	endfunction : dar_mapped

	// configuration and software state
	logic [3:0] cl_r; // cas latency in clocks
	logic [3:0] al_r; // additive latency in clocks
	logic [1:0] bl_r; // burst length mode
	logic [dar_pkg::WORD_AW-1:0] maddr_r; // array load pointer
	logic [dar_pkg::VIOL_W-1:0] viol_r; // sticky protocol violations
	logic [dar_pkg::VIOL_W-1:0] v_set; // violations seen this cycle
	logic [31:0] prdata_r; // read data captured in setup
	// command decode
	logic act_cmd, rd_cmd, wr_cmd, pre_cmd;
	logic rd_acc; // read taken into the latency pipe
	logic act_acc; // activate taken
	logic cmd_bc4; // this read is a chopped burst
	// per-bank state
	logic [dar_pkg::BANKS-1:0] open_r;
	logic [dar_pkg::BANKS-1:0] ap_pend_r;
	logic [dar_pkg::BANKS-1:0] ap_fire;
	logic [dar_pkg::BANKS-1:0] pre_fire;
	logic [5:0] age_r [dar_pkg::BANKS];
	logic [4:0] rp_cnt_r [dar_pkg::BANKS];
	logic [5:0] ap_cnt_r [dar_pkg::BANKS];
	// read latency pipe and burst engine
	dar_pkg::dar_rd_t pipe_r [RL_MAX];
	dar_pkg::dar_rd_t tap, early;
	logic [4:0] rl; // read latency al plus cl
	dar_pkg::dar_bst_t bst_r;
	logic [1:0] cnt_r; // clocks still to issue
	logic [1:0] k_r; // clock index inside burst
	logic [dar_pkg::BA_W-1:0] bk_r;
	logic [dar_pkg::COL_W-1:0] col_r;
	logic bc4_r;
	logic tap_start; // burst begins this cycle
	logic mem_re;
	logic [dar_pkg::WORD_AW-1:0] mem_raddr;
	logic last_nxt, pre_nxt;
	logic dq_oe_r, dqs_oe_r, dqs_low_r, dqs_o_r, dqs_b_r;
	logic any_pend; // any read in flight

	// command pin decode
	always_comb
	begin
		{act_cmd, rd_cmd, wr_cmd, pre_cmd} = dar_decode(cmd);
	end

	assign rl = 5'(al_r) + 5'(cl_r);

	// burst length per mode register field, A12 picks in on-the-fly mode
	always_comb
	begin
		unique case (bl_r)
			dar_pkg::BL_FIX4: cmd_bc4 = 1'b1;
			dar_pkg::BL_OTF: cmd_bc4 = !cmd.addr[dar_pkg::BC_BIT];
			default: cmd_bc4 = 1'b0;
		endcase
	end

	// a read needs an open bank whose gap plus al meets the row-to-column time
	assign rd_acc = rd_cmd && open_r[cmd.ba] && !ap_pend_r[cmd.ba] &&
		(7'(age_r[cmd.ba]) + 7'(al_r) >= 7'(dar_pkg::RCD_CYC));
	// activate refused while the bank is open or still precharging
	assign act_acc = act_cmd && !open_r[cmd.ba] && rp_cnt_r[cmd.ba] == 5'h0;

	// per-bank row state, timers and auto precharge
	for (genvar b = 0; b < dar_pkg::BANKS; b++)
	begin : g_bank
		logic hit;
		assign hit = cmd.ba == dar_pkg::BA_W'(b);
		// internal precharge once tRTP and tRAS both hold
		assign ap_fire[b] = ap_pend_r[b] && ap_cnt_r[b] <= 6'h1 && age_r[b] >= 6'(dar_pkg::RAS_CYC);
		assign pre_fire[b] = (pre_cmd && hit) || ap_fire[b];

		// open on activate, close on any precharge
		always_ff @(posedge clk_sys or negedge rst_b)
		begin
			if (!rst_b)
				open_r[b] <= 1'b0;
			else if (act_acc && hit)
				open_r[b] <= 1'b1;
			else if (pre_fire[b])
				open_r[b] <= 1'b0;
		end

		// clocks since activate, saturating
		always_ff @(posedge clk_sys or negedge rst_b)
		begin
			if (!rst_b)
				age_r[b] <= 6'h0;
			else if (act_acc && hit)
				age_r[b] <= 6'h1;
			else if (age_r[b] != 6'h3F)
				age_r[b] <= age_r[b] + 6'h1;
		end

		// precharge period counted from the last precharge, internal or commanded
		always_ff @(posedge clk_sys or negedge rst_b)
		begin
			if (!rst_b)
				rp_cnt_r[b] <= 5'h0;
			else if (pre_fire[b])
				rp_cnt_r[b] <= 5'(dar_pkg::RP_CYC);
			else if (rp_cnt_r[b] != 5'h0)
				rp_cnt_r[b] <= rp_cnt_r[b] - 5'h1;
		end

		// auto precharge armed by A10 on an accepted read
		always_ff @(posedge clk_sys or negedge rst_b)
		begin
			if (!rst_b)
			begin
				ap_pend_r[b] <= 1'b0;
				ap_cnt_r[b] <= 6'h0;
			end
			else if (rd_acc && hit && cmd.addr[dar_pkg::AP_BIT])
			begin
				ap_pend_r[b] <= 1'b1;
				ap_cnt_r[b] <= 6'(al_r) + 6'(dar_pkg::RTP_EFF);
			end
			else
			begin
				if (ap_fire[b] || (pre_cmd && hit))
					ap_pend_r[b] <= 1'b0;
				if (ap_cnt_r[b] != 6'h0)
					ap_cnt_r[b] <= ap_cnt_r[b] - 6'h1;
			end
		end

		chk_ap_arms_a10: assert property (rd_acc && hit && cmd.addr[dar_pkg::AP_BIT] |=> ap_pend_r[b])
			else $error("auto precharge not armed by A10 read");
		// no fire in the first three clocks after arming, so the row closes no sooner than the fourth edge after the read
		chk_ap_not_early: assert property ($rose(ap_pend_r[b]) |-> !ap_fire[b] [*3])
			else $error("internal precharge within four clocks of read");
		chk_rp_restart: assert property (pre_fire[b] |=> rp_cnt_r[b] == 5'(dar_pkg::RP_CYC) && !open_r[b])
			else $error("precharge period not restarted");
		chk_ap_ras_lock: assert property ($fell(open_r[b]) && !$past(pre_cmd && hit) |->
			$past(age_r[b]) >= 6'(dar_pkg::RAS_CYC))
			else $error("auto precharge before row active time");
	end

	// read latency pipe, one stage per clock
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < RL_MAX; i++)
				pipe_r[i] <= '0;
		end
		else
		begin
			pipe_r[0] <= '{vld: rd_acc, ba: cmd.ba, col: cmd.addr[dar_pkg::COL_W-1:0], bc4: cmd_bc4};
			for (int i = 1; i < RL_MAX; i++)
				pipe_r[i] <= pipe_r[i-1];
		end
	end

	// taps: array read one clock before data, preamble one clock before that
	always_comb
	begin
		tap = pipe_r[rl - 5'h2];
		early = pipe_r[rl - 5'h3];
		any_pend = bst_r == dar_pkg::BST_RUN;
		for (int i = 0; i < RL_MAX; i++)
			any_pend = any_pend || pipe_r[i].vld;
	end

	// a tap that lands on a running burst is dropped so the burst completes
	assign tap_start = tap.vld && bst_r == dar_pkg::BST_IDLE;
	assign mem_re = tap_start || bst_r == dar_pkg::BST_RUN;
	assign mem_raddr = tap_start ? dar_waddr(tap.ba, tap.col, 2'h0, tap.bc4) : dar_waddr(bk_r, col_r, k_r, bc4_r);
	assign last_nxt = bst_r == dar_pkg::BST_RUN && cnt_r == 2'h1;
	// preamble only when the strobe is not already running
	assign pre_nxt = early.vld && !mem_re;

	// burst engine: one array word, two beats, per clock
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bst_r <= dar_pkg::BST_IDLE;
			cnt_r <= 2'h0;
			k_r <= 2'h0;
			bk_r <= '0;
			col_r <= '0;
			bc4_r <= 1'b0;
		end
		else
		begin
			unique case (bst_r)
				dar_pkg::BST_IDLE:
				begin
					if (tap_start)
					begin
						bst_r <= dar_pkg::BST_RUN;
						cnt_r <= tap.bc4 ? dar_pkg::CYC_BC4 : dar_pkg::CYC_BL8;
						k_r <= 2'h1;
						bk_r <= tap.ba;
						col_r <= tap.col;
						bc4_r <= tap.bc4;
					end
				end
				dar_pkg::BST_RUN:
				begin
					// run to the end regardless of later commands
					cnt_r <= cnt_r - 2'h1;
					k_r <= k_r + 2'h1;
					if (cnt_r == 2'h1)
						bst_r <= dar_pkg::BST_IDLE;
				end
			endcase
		end
	end

	// data and strobe drive, all from flops
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dq_oe_r <= 1'b0;
			dqs_oe_r <= 1'b0;
			dqs_low_r <= 1'b0;
			dqs_o_r <= 1'b0;
			dqs_b_r <= 1'b0;
		end
		else
		begin
			dq_oe_r <= mem_re;
			dqs_oe_r <= mem_re || pre_nxt;
			dqs_low_r <= pre_nxt || last_nxt;
			dqs_o_r <= mem_re && !last_nxt;
			dqs_b_r <= pre_nxt || last_nxt || !mem_re;
		end
	end

	assign dq_oe = dq_oe_r;
	assign dqs_oe = dqs_oe_r;
	assign dqs_o = dqs_o_r;
	assign dqs_b_o = dqs_b_r;

	// data array, low half rising-edge beat, high half falling-edge beat
	dar_mem #(
		.AW(dar_pkg::WORD_AW),
		.DW(2 * DQ_W)
	) u_mem (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.we(psel && penable && pwrite && paddr == dar_pkg::REG_MDATA),
		.waddr(maddr_r),
		.wdata(pwdata[2*DQ_W-1:0]),
		.re(mem_re),
		.raddr(mem_raddr),
		.rdata_r(dq_o)
	);

	// violations seen on the command pins and the burst engine
	always_comb
	begin
		v_set = '0;
		v_set[dar_pkg::V_CLOSED] = (rd_cmd || wr_cmd) && !open_r[cmd.ba];
		v_set[dar_pkg::V_RCD] = rd_cmd && open_r[cmd.ba] && !rd_acc;
		v_set[dar_pkg::V_RP] = act_cmd && !act_acc;
		v_set[dar_pkg::V_TRUNC] = tap.vld && bst_r == dar_pkg::BST_RUN;
	end

	// apb register writes
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cl_r <= dar_pkg::CL_RST;
			al_r <= dar_pkg::AL_RST;
			bl_r <= dar_pkg::BL_FIX8;
			maddr_r <= '0;
		end
		else if (psel && penable && pwrite)
		begin
			if (paddr == dar_pkg::REG_CFG)
			begin
				cl_r <= pwdata[dar_pkg::CFG_CL_LSB +: 4];
				al_r <= pwdata[dar_pkg::CFG_AL_LSB +: 4];
				bl_r <= pwdata[dar_pkg::CFG_BL_LSB +: 2];
			end
			else if (paddr == dar_pkg::REG_MADDR)
				maddr_r <= pwdata[dar_pkg::WORD_AW-1:0];
			else if (paddr == dar_pkg::REG_MDATA)
				maddr_r <= maddr_r + 1'b1;
		end
	end

	// sticky violations, write one to clear, a new event wins over the clear
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			viol_r <= '0;
		else if (psel && penable && pwrite && paddr == dar_pkg::REG_VIOL)
			viol_r <= (viol_r & ~pwdata[dar_pkg::VIOL_W-1:0]) | v_set;
		else
			viol_r <= viol_r | v_set;
	end

	// read data captured in the setup phase
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			prdata_r <= 32'h0000_0000;
		else if (psel && !penable)
		begin
			prdata_r <= 32'h0000_0000;
			unique case (paddr)
				dar_pkg::REG_CFG: prdata_r <= 32'({bl_r, al_r, cl_r});
				dar_pkg::REG_MADDR: prdata_r <= 32'(maddr_r);
				dar_pkg::REG_STAT: prdata_r <= 32'({ap_pend_r, 7'h00, any_pend, open_r});
				dar_pkg::REG_VIOL: prdata_r <= 32'(viol_r);
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !dar_mapped(paddr);

	// each rise of data enable traces back to a read taken exactly rl clocks earlier, for rl from 3 to RL_MAX
	for (genvar r = 3; r <= RL_MAX; r++)
	begin : g_rl
		chk_first_data_rl: assert property ($rose(dq_oe_r) && rl == 5'(r) |-> $past(rd_acc, r))
			else $error("first data not at read latency");
	end
	chk_burst_beats: assert property ($rose(dq_oe_r) |-> dq_oe_r [*2])
		else $error("burst shorter than two clocks");
	chk_preamble_low: assert property ($rose(dq_oe_r) |-> $past(dqs_oe_r && dqs_low_r))
		else $error("no strobe preamble before data");
	chk_postamble_last: assert property ($fell(dq_oe_r) |-> $past(dqs_low_r))
		else $error("no strobe postamble on last data");
	chk_release_hiz: assert property ($fell(dq_oe_r) && !dqs_low_r |-> !dqs_oe_r)
		else $error("strobe still driven after burst");
	chk_no_truncate: assert property (bst_r == dar_pkg::BST_RUN && cnt_r == 2'h2 |=> bst_r == dar_pkg::BST_RUN)
		else $error("read burst truncated");
	chk_rcd_gate: assert property (rd_cmd && 7'(age_r[cmd.ba]) + 7'(al_r) < 7'(dar_pkg::RCD_CYC) |=>
		viol_r[dar_pkg::V_RCD] && !pipe_r[0].vld)
		else $error("early read accepted");
	chk_bc4_gap: assert property (tap_start && tap.bc4 |=> ##1 bst_r == dar_pkg::BST_IDLE)
		else $error("chopped burst length wrong");

	cov_bl8_burst: cover property (tap_start && !tap.bc4 ##4 !dq_oe_r);
	cov_bc4_burst: cover property (tap_start && tap.bc4);
	cov_gapless: cover property (last_nxt ##1 tap_start);
	cov_auto_pre: cover property (|ap_fire);
endmodule : dar_core

// ==== verif/dar_ctl_model.sv ====
// controller stand-in: issues activate, read and precharge commands with the spacing it owes
`timescale 1ns/100ps
module dar_ctl_model (
	input wire logic clk_sys,
	input wire logic [3:0] al,
	output dar_pkg::dar_cmd_t cmd
);
	// spacings that the device side does not fix; plain defaults
	localparam int CCD = 4;
	localparam int RRD = 2;
	localparam int FAW = 16;
	localparam int CWL = 5; // write latency without al
	int cyc; // count of rising edges seen
	int act_at [dar_pkg::BANKS]; // edge of the last activate per bank
	int pre_at [dar_pkg::BANKS]; // edge at which each bank began precharging
	int rd_at; // edge of the last read
	int acts [$]; // edges of all activates, oldest first

	// idle pins deselect the device
	initial
	begin
		cmd = '1;
		cyc = 0;
		rd_at = -100;
		foreach (act_at[i])
		begin
			act_at[i] = -100;
			pre_at[i] = -100;
		end
	end

	// edge counter behind every spacing decision
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
	end

	// larger of two edge numbers
	function automatic int mx(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : mx

	// drive one command sampled no earlier than edge t, then deselect again
	task automatic issue(input int t, input logic [2:0] op, input logic [2:0] ba, input logic [13:0] a, output int s);
		do
		begin
			@(posedge clk_sys);
		end while (cyc < t - 1);
		cmd <= '{cs_b: 1'b0, ras_b: op[2], cas_b: op[1], we_b: op[0], ba: ba, addr: a};
		s = cyc + 1;
		@(posedge clk_sys);
		cmd <= '1;
	endtask : issue

	// open a row; strict waits out every activate spacing, otherwise fires at once
	task automatic act(input logic [2:0] ba, input logic [13:0] row, input logic strict);
		int t;
		int s;
		t = 0;
		if (strict)
		begin
			t = mx(act_at[ba] + dar_pkg::RAS_CYC + dar_pkg::RP_CYC, pre_at[ba] + dar_pkg::RP_CYC);
			foreach (act_at[i]) t = mx(t, act_at[i] + RRD);
			if (acts.size() >= 4) t = mx(t, acts[acts.size() - 4] + FAW);
		end
		issue(t, 3'h3, ba, row, s);
		act_at[ba] = s;
		acts.push_back(s);
	endtask : act

	// read burst; a10 asks for auto precharge, a12 picks eight beats in on-the-fly mode
	task automatic rd(input logic [2:0] ba, input logic [9:0] col, input logic ap, input logic bl8,
		input logic strict);
		int t;
		int s;
		t = 0;
		if (strict)
		begin
			t = mx(act_at[ba] + dar_pkg::RCD_CYC - int'(al), rd_at + CCD);
		end
		issue(t, 3'h5, ba, {1'b0, bl8, 1'b0, ap, col}, s);
		rd_at = s;
		if (ap)
		begin
			pre_at[ba] = mx(s + int'(al) + dar_pkg::RTP_EFF, act_at[ba] + dar_pkg::RAS_CYC);
		end
	endtask : rd

	// close a bank; strict keeps the read-to-precharge spacing
	task automatic pre(input logic [2:0] ba, input logic strict);
		int t;
		int s;
		t = strict ? mx(rd_at + 4, rd_at + int'(al) + dar_pkg::RTP_CYC) : 0;
		issue(t, 3'h2, ba, 14'h0000, s);
		pre_at[ba] = s;
	endtask : pre

	// write command; strict lets the last read's data clear the bus first
	task automatic wr(input logic [2:0] ba, input logic [9:0] col, input logic strict);
		int t;
		int s;
		t = strict ? rd_at + int'(dar_pkg::CL_RST) + CCD - CWL + 2 : 0;
		issue(t, 3'h4, ba, {4'h0, col}, s);
	endtask : wr
endmodule : dar_ctl_model

// ==== verif/dar_core_tb.sv ====
// self-checking bench for the row activation and read burst block
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin num_errors++; \
	$display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module dar_core_tb;
	logic clk_sys; // 250 MHz system clock
	logic rst_b; // active-low reset
	logic [7:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	dar_pkg::dar_cmd_t cmd; // command pins from the controller model
	logic [15:0] dq_o;
	logic dq_oe;
	logic dqs_o;
	logic dqs_b_o;
	logic dqs_oe;
	logic [3:0] al_cur; // additive latency now programmed
	logic [31:0] rdat; // last word read back
	logic rerr; // last error response
	int num_errors;
	int checks;

	dar_core #(.DQ_W(8)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd(cmd),
		.dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_b_o(dqs_b_o), .dqs_oe(dqs_oe));
	dar_ctl_model ctl (.clk_sys(clk_sys), .al(al_cur), .cmd(cmd));

	// free-running clock, 4 ns period
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// prints the counts and the verdict, then stops
	task results;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
		begin
			$display("No errors found");
		end
		else
		begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// one bus transfer: setup, then access held until pready
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// program burst mode and additive latency, cas latency kept at five
	task automatic cfg(input logic [1:0] bl, input logic [3:0] al);
		al_cur = al;
		apb(1'b1, dar_pkg::REG_CFG, {22'h000000, bl, al, dar_pkg::CL_RST});
	endtask : cfg

	// compare the violation flags, then clear them
	task automatic viol(input logic [3:0] ex);
		apb(1'b0, dar_pkg::REG_VIOL, 32'h00000000);
		`CHK("viol", ex, rdat[3:0])
		apb(1'b1, dar_pkg::REG_VIOL, 32'h0000000F);
	endtask : viol

	// one read from bank one, watched cycle by cycle from command to release
	task automatic burst(input logic [9:0] col, input logic a12, input int n);
		logic [1:0] w;
		int rl;
		rl = int'(al_cur) + 5;
		ctl.rd(3'h1, col, 1'b0, a12, 1'b1);
		repeat (rl - 2)
		begin
			@(posedge clk_sys);
			#1;
			`CHK("early", 1'b0, dq_oe)
		end
		`CHK("preamble", 3'h5, {dqs_oe, dqs_o, dqs_b_o})
		for (int k = 0; k < n; k++)
		begin
			@(posedge clk_sys);
			#1;
			w = (n == 4) ? col[2:1] + k[1:0] : {col[2], col[1] ^ k[0]};
			`CHK("data", {2'h3, 16'h5A00 + {col[3], w}}, {dq_oe, dqs_oe, dq_o})
			`CHK("strobe", {k != n - 1, k == n - 1}, {dqs_o, dqs_b_o})
		end
		@(posedge clk_sys);
		#1;
		`CHK("release", 2'h0, {dq_oe, dqs_oe})
	endtask : burst

	// reset values, unmapped access, array preload, opening bank one
	task automatic t_regs;
		apb(1'b0, dar_pkg::REG_CFG, 32'h00000000);
		`CHK("cfg", 10'h005, rdat[9:0])
		apb(1'b0, 8'h14, 32'h00000000);
		`CHK("unmapped", 33'h000000001, {rdat, rerr})
		apb(1'b1, dar_pkg::REG_MADDR, 32'h00000200);
		for (int i = 0; i < 8; i++) apb(1'b1, dar_pkg::REG_MDATA, 32'h00005A00 + 32'(i));
		ctl.act(3'h1, 14'h0123, 1'b1);
		apb(1'b0, dar_pkg::REG_STAT, 32'h00000000);
		`CHK("open", 8'h02, rdat[7:0])
		$display("test registers done");
	endtask : t_regs

	// every burst mode; fixed eight and on-the-fly four without additive latency, fixed four and on-the-fly eight with it
	task automatic t_bursts;
		for (int i = 0; i < 4; i++)
		begin
			cfg(i == 0 ? dar_pkg::BL_FIX8 : (i == 1 ? dar_pkg::BL_FIX4 : dar_pkg::BL_OTF), i[0] ? 4'h2 : 4'h0);
			burst(10'h006, i[0], (i == 0 || i == 3) ? 4 : 2);
		end
		$display("test burst modes done");
	endtask : t_bursts

	// two reads four clocks apart: gapless for eight beats, gap for four
	task automatic t_concat(input logic bl8);
		logic e;
		int n;
		n = bl8 ? 4 : 2;
		cfg(dar_pkg::BL_OTF, 4'h0);
		ctl.rd(3'h1, 10'h000, 1'b0, bl8, 1'b1);
		ctl.rd(3'h1, 10'h008, 1'b0, bl8, 1'b1);
		for (int k = 1; k <= 10; k++)
		begin
			@(posedge clk_sys);
			#1;
			e = (k < n) || (k >= 4 && k < 4 + n);
			`CHK("concat", e, dq_oe)
		end
		ctl.wr(3'h1, 10'h000, 1'b1);
		$display("test concat done");
	endtask : t_concat

	// a read landing in a running burst is dropped, the burst runs out whole
	task automatic t_trunc;
		int cnt;
		cnt = 0;
		cfg(dar_pkg::BL_FIX8, 4'h0);
		ctl.rd(3'h1, 10'h000, 1'b0, 1'b1, 1'b1);
		ctl.rd(3'h1, 10'h008, 1'b0, 1'b1, 1'b0);
		repeat (12)
		begin
			@(posedge clk_sys);
			#1;
			cnt += (dq_oe === 1'b1) ? 1 : 0;
		end
		`CHK("beats", 4, cnt)
		viol(4'h8);
		$display("test truncation done");
	endtask : t_trunc

	// read to a closed bank, read too soon after activate, activate of an open bank
	task automatic t_refuse;
		ctl.rd(3'h2, 10'h000, 1'b0, 1'b1, 1'b0);
		ctl.act(3'h2, 14'h0040, 1'b1);
		ctl.rd(3'h2, 10'h000, 1'b0, 1'b1, 1'b0);
		ctl.act(3'h1, 14'h0050, 1'b0);
		viol(4'h7);
		$display("test refusals done");
	endtask : t_refuse

	// auto precharge closes the bank, then precharge period guards reopening
	task automatic t_autopre;
		ctl.rd(3'h1, 10'h000, 1'b1, 1'b1, 1'b1);
		repeat (3) @(posedge clk_sys);
		ctl.act(3'h1, 14'h0060, 1'b0);
		ctl.act(3'h1, 14'h0060, 1'b1);
		apb(1'b0, dar_pkg::REG_STAT, 32'h00000000);
		`CHK("reopen", 2'h1, {rdat[17], rdat[1]})
		viol(4'h4);
		ctl.pre(3'h1, 1'b1);
		ctl.act(3'h1, 14'h0070, 1'b0);
		apb(1'b0, dar_pkg::REG_STAT, 32'h00000000);
		`CHK("closed", 1'b0, rdat[1])
		viol(4'h4);
		$display("test auto precharge done");
	endtask : t_autopre

	// main sequence
	initial
	begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		al_cur = 4'h0;
		num_errors = 0;
		checks = 0;
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_regs();
		t_bursts();
		t_concat(1'b1);
		t_concat(1'b0);
		t_trunc();
		t_refuse();
		t_autopre();
		results();
	end

	// watchdog cuts a hang short
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		$display("mismatch watchdog expected done seen hang");
		results();
	end
endmodule : dar_core_tb
